/* design/fsq_cfg.svh */
// Constants for the flash self-programming sequencer: register offsets,
// control field positions, pointer modes, key bytes and timing figures.
// Assumes inclusion by bare name from the package and design modules.
`ifndef FSQ_CFG_SVH
`define FSQ_CFG_SVH

// Register offsets on the 3-bit register port
`define FSQ_OFS_CTRL 3'h0
`define FSQ_OFS_KEY 3'h1
`define FSQ_OFS_PTR_L 3'h2
`define FSQ_OFS_PTR_H 3'h3
`define FSQ_OFS_PTR_U 3'h4
`define FSQ_OFS_LATCH 3'h5
`define FSQ_OFS_TBLOP 3'h6

// Field positions in flash_control_reg
`define FSQ_BIT_PMSEL 7
`define FSQ_BIT_CFGSEL 6
`define FSQ_BIT_ERASE 4
`define FSQ_BIT_WERR 3
`define FSQ_BIT_WRITE_ENABLE_BIT 2
`define FSQ_BIT_START 1

// Field positions in the table operation trigger register
`define FSQ_BIT_TBL_READ 2
`define FSQ_TBL_MODE_HI 1

// Table pointer update modes
`define FSQ_MODE_NONE 2'h0
`define FSQ_MODE_POSTINC 2'h1
`define FSQ_MODE_POSTDEC 2'h2
`define FSQ_MODE_PREINC 2'h3

// Unlock key bytes and the erased byte value
`define FSQ_KEY_FIRST 8'h55
`define FSQ_KEY_SECOND 8'haa
`define FSQ_ERASED_BYTE 8'hff

// Write block geometry
`define FSQ_BLOCK_BYTES 64
`define FSQ_BLOCK_BITS 6

// Long write duration and clock period
`define FSQ_LONG_WRITE_NS 2000000
`define FSQ_CLK_PERIOD_NS 100
`define FSQ_TIMER_WIDTH 24

`endif

/* design/fsq_hold_bank.sv */
// Holding register bank: one byte per byte of the write block.
// Assumes one writer at a time; a clear wins over a table write.
`default_nettype none
`include "fsq_cfg.svh"

module fsq_hold_bank
  import fsq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Sequencer side
  fsq_hold_if.bank hold
);

  fsq_bank_st_t r; // Registered bank
  fsq_bank_st_t n; // Next bank

  // Next state: clear, reset or one table write
  always_comb begin
    n = r;
    if (reset_i || hold.clr) begin
      for (int i = 0; i < `FSQ_BLOCK_BYTES; i++) begin
        n.mem[i] = `FSQ_ERASED_BYTE;
      end
    end else if (hold.wr) begin
      n.mem[hold.wr_idx] = hold.wr_data;
    end
  end

  // Register the bank
  always_ff @(posedge clk_i) begin
    r <= n;
  end

  // Byte presented to the programming walk
  assign hold.rd_data = r.mem[hold.rd_idx];

endmodule

`default_nettype wire

/* design/fsq_hold_if.sv */
// Link between the sequencer and its holding register bank.
// Assumes both ends sit on the same clock.
`default_nettype none
`include "fsq_cfg.svh"

interface fsq_hold_if;
  logic wr;                              // Table write strobe
  logic [`FSQ_BLOCK_BITS-1:0] wr_idx;    // Holding register select
  logic [7:0] wr_data;                   // Byte from the table latch
  logic clr;                             // Return all bytes to erased
  logic [`FSQ_BLOCK_BITS-1:0] rd_idx;    // Byte picked while programming
  logic [7:0] rd_data;                   // Selected holding byte

  modport seq (output wr, wr_idx, wr_data, clr, rd_idx, input rd_data);
  modport bank (input wr, wr_idx, wr_data, clr, rd_idx, output rd_data);
endinterface

`default_nettype wire

/* design/fsq_pkg.sv */
// Types shared by the flash self-programming sequencer modules.
// Assumes fsq_cfg.svh is on the include path.
`default_nettype none
`include "fsq_cfg.svh"

package fsq_pkg;

  // Long write sequencer states
  typedef enum logic [1:0] {
    FSQ_ST_IDLE,
    FSQ_ST_ERASE,
    FSQ_ST_PROG,
    FSQ_ST_WAIT
  } fsq_state_t;

  // Unlock key tracker states
  typedef enum logic [1:0] {
    FSQ_KEY_IDLE,
    FSQ_KEY_GOT1,
    FSQ_KEY_ARMED
  } fsq_key_t;

  // Holding register bank state
  typedef struct packed {
    logic [`FSQ_BLOCK_BYTES-1:0][7:0] mem;
  } fsq_bank_st_t;

  // Sequencer state
  typedef struct packed {
    fsq_state_t state;
    fsq_key_t key;
    logic pmsel;
    logic cfgsel;
    logic erase_sel;
    logic werr;
    logic write_enable_bit;
    logic start;
    logic [21:0] ptr;
    logic [7:0] latch;
    logic [`FSQ_TIMER_WIDTH-1:0] timer;
    logic [`FSQ_BLOCK_BITS:0] idx;
    logic rd_pend;
    logic [7:0] rdata;
    logic stall;
    logic [21:0] faddr;
    logic [7:0] fwdata;
    logic fprog;
    logic ferase;
    logic frd;
  } fsq_seq_st_t;

endpackage

`default_nettype wire

/* design/fsq_sequencer.sv */
// Flash self-programming sequencer: control, unlock key, table pointer,
// table latch and the timed long write, with its holding register bank.
// Assumes a flash array on the same clock that answers a read one cycle
// after flash_rd_o and takes program and erase strobes as given.
//
// The placing of the registers and strobed register access are this design's own decisions.
`default_nettype none
`include "fsq_cfg.svh"

module fsq_sequencer
  import fsq_pkg::*;
#(
  // Long write length in clock cycles
  parameter int LONG_CYC = (`FSQ_LONG_WRITE_NS / `FSQ_CLK_PERIOD_NS)
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  // Core stall
  output logic cpu_stall_o,
  // Flash array
  output logic [21:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  output logic flash_prog_o,
  output logic flash_erase_o,
  output logic flash_rd_o,
  input wire logic [7:0] flash_rdata_i
);

  // The programming walk must end before the timer does
  if (LONG_CYC < `FSQ_BLOCK_BYTES + 2 || LONG_CYC >= (1 << `FSQ_TIMER_WIDTH))
  begin : g_check
    $error("fsq_sequencer: LONG_CYC out of range");
  end

  localparam logic [`FSQ_TIMER_WIDTH-1:0] TIMER_LOAD =
    `FSQ_TIMER_WIDTH'(LONG_CYC - 1);
  localparam logic [`FSQ_BLOCK_BITS:0] LAST_IDX =
    (`FSQ_BLOCK_BITS+1)'(`FSQ_BLOCK_BYTES - 1);

  fsq_seq_st_t r; // Registered state
  fsq_seq_st_t n; // Next state
  fsq_hold_if hold (); // Link to the holding bank

  // Holding register bank
  fsq_hold_bank u_bank (
    .clk_i(clk_i),
    .reset_i(reset_i || por_i),
    .hold(hold.bank)
  );

  logic [7:0] ctrl_rd; // Control register as read back
  logic start_req; // Software asks for a long write
  logic start_ok; // The request passes every guard
  logic [1:0] tbl_mode; // Pointer update mode of a table op
  logic [20:0] ptr_step; // Pointer low 21 bits after inc or dec

  // Control register read view; unused bits read as zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`FSQ_BIT_PMSEL] = r.pmsel;
    ctrl_rd[`FSQ_BIT_CFGSEL] = r.cfgsel;
    ctrl_rd[`FSQ_BIT_ERASE] = r.erase_sel;
    ctrl_rd[`FSQ_BIT_WERR] = r.werr;
    ctrl_rd[`FSQ_BIT_WRITE_ENABLE_BIT] = r.write_enable_bit;
    ctrl_rd[`FSQ_BIT_START] = r.start;
  end

  // Main next-state logic
  always_comb begin
    n = r;
    // Strobes last one cycle
    n.fprog = 1'b0;
    n.ferase = 1'b0;
    n.frd = 1'b0;
    // Array answers a cycle after its strobe, so take the latch then
    n.rd_pend = r.frd;
    n.rdata = 8'h00;
    hold.wr = 1'b0;
    hold.wr_idx = r.ptr[`FSQ_BLOCK_BITS-1:0];
    hold.wr_data = r.latch;
    hold.clr = 1'b0;
    hold.rd_idx = r.idx[`FSQ_BLOCK_BITS-1:0];
    tbl_mode = wdata_i[`FSQ_TBL_MODE_HI:0];
    ptr_step = r.ptr[20:0];
    start_req = 1'b0;
    start_ok = 1'b0;

    // Table read data returns a cycle after the array strobe
    if (r.rd_pend) begin
      n.latch = flash_rdata_i;
    end

    // Read port; data stands in the next cycle only
    if (re_i) begin
      if (addr_i == `FSQ_OFS_CTRL) begin
        n.rdata = ctrl_rd;
      end else if (addr_i == `FSQ_OFS_PTR_L) begin
        n.rdata = r.ptr[7:0];
      end else if (addr_i == `FSQ_OFS_PTR_H) begin
        n.rdata = r.ptr[15:8];
      end else if (addr_i == `FSQ_OFS_PTR_U) begin
        n.rdata = {2'b00, r.ptr[21:16]};
      end else if (addr_i == `FSQ_OFS_LATCH) begin
        n.rdata = r.latch;
      end else begin
        // Key register is not storage; it and unmapped offsets read 0
        n.rdata = 8'h00;
      end
    end

    // Writes count only while idle: the core is stalled otherwise
    if (we_i && r.state == FSQ_ST_IDLE) begin
      // Any write other than the next key step disarms the unlock
      n.key = FSQ_KEY_IDLE;
      if (addr_i == `FSQ_OFS_KEY) begin
        if (wdata_i == `FSQ_KEY_FIRST) begin
          n.key = FSQ_KEY_GOT1;
        end else if (wdata_i == `FSQ_KEY_SECOND &&
                     r.key == FSQ_KEY_GOT1) begin
          n.key = FSQ_KEY_ARMED;
        end
      end else if (addr_i == `FSQ_OFS_CTRL) begin
        n.pmsel = wdata_i[`FSQ_BIT_PMSEL];
        n.cfgsel = wdata_i[`FSQ_BIT_CFGSEL];
        n.erase_sel = wdata_i[`FSQ_BIT_ERASE];
        n.write_enable_bit = wdata_i[`FSQ_BIT_WRITE_ENABLE_BIT];
        // Software may clear the error flag but never set it
        if (!wdata_i[`FSQ_BIT_WERR]) begin
          n.werr = 1'b0;
        end
        // Writing zero to start has no effect
        start_req = wdata_i[`FSQ_BIT_START];
        start_ok = r.key == FSQ_KEY_ARMED && wdata_i[`FSQ_BIT_WRITE_ENABLE_BIT] &&
                   wdata_i[`FSQ_BIT_PMSEL] && !wdata_i[`FSQ_BIT_CFGSEL];
      end else if (addr_i == `FSQ_OFS_PTR_L) begin
        n.ptr[7:0] = wdata_i;
      end else if (addr_i == `FSQ_OFS_PTR_H) begin
        n.ptr[15:8] = wdata_i;
      end else if (addr_i == `FSQ_OFS_PTR_U) begin
        n.ptr[21:16] = wdata_i[5:0];
      end else if (addr_i == `FSQ_OFS_LATCH) begin
        n.latch = wdata_i;
      end else if (addr_i == `FSQ_OFS_TBLOP) begin
        // Pointer steps touch only the low 21 bits
        if (tbl_mode == `FSQ_MODE_POSTDEC) begin
          ptr_step = r.ptr[20:0] - 21'h000001;
        end else if (tbl_mode != `FSQ_MODE_NONE) begin
          ptr_step = r.ptr[20:0] + 21'h000001;
        end
        n.ptr[20:0] = ptr_step;
        if (wdata_i[`FSQ_BIT_TBL_READ]) begin
          // Table read: fetch from the array into the latch
          n.frd = 1'b1;
          n.faddr = (tbl_mode == `FSQ_MODE_PREINC) ?
                    {r.ptr[21], ptr_step} : r.ptr;
        end else begin
          // Table write: one holding byte, short and unstalled
          hold.wr = 1'b1;
          hold.wr_idx = (tbl_mode == `FSQ_MODE_PREINC) ?
                        ptr_step[`FSQ_BLOCK_BITS-1:0] :
                        r.ptr[`FSQ_BLOCK_BITS-1:0];
        end
      end
    end

    // Start request: launch a long write or flag the bad attempt
    if (start_req && !r.start) begin
      if (start_ok) begin
        n.start = 1'b1;
        n.stall = 1'b1;
        n.timer = TIMER_LOAD;
        n.idx = '0;
        n.state = n.erase_sel ? FSQ_ST_ERASE : FSQ_ST_PROG;
      end else begin
        n.werr = 1'b1;
      end
    end

    // Timed long write
    case (r.state)
      FSQ_ST_IDLE: begin
      end
      FSQ_ST_ERASE: begin
        // One erase strobe on the 64-byte block of the pointer
        n.ferase = 1'b1;
        n.faddr = {r.ptr[21:`FSQ_BLOCK_BITS],
                   `FSQ_BLOCK_BITS'(0)};
        n.timer = r.timer - 1'b1;
        n.state = FSQ_ST_WAIT;
      end
      FSQ_ST_PROG: begin
        // Walk the whole block; erased bytes raise no strobe
        n.faddr = {r.ptr[21:`FSQ_BLOCK_BITS],
                   r.idx[`FSQ_BLOCK_BITS-1:0]};
        n.fwdata = hold.rd_data;
        n.fprog = hold.rd_data != `FSQ_ERASED_BYTE;
        n.idx = r.idx + 1'b1;
        n.timer = r.timer - 1'b1;
        if (r.idx == LAST_IDX) begin
          n.state = FSQ_ST_WAIT;
        end
      end
      FSQ_ST_WAIT: begin
        // The timer alone ends the cycle and releases the core
        if (r.timer == '0) begin
          n.state = FSQ_ST_IDLE;
          n.stall = 1'b0;
          n.start = 1'b0;
          hold.clr = 1'b1;
        end else begin
          n.timer = r.timer - 1'b1;
        end
      end
      default: begin
        n.state = FSQ_ST_IDLE;
      end
    endcase

    // Device reset: a long write cut short by reset_i leaves the error flag set; por_i clears it
    if (reset_i || por_i) begin
      n = '0;
      n.state = FSQ_ST_IDLE;
      n.key = FSQ_KEY_IDLE;
      n.werr = !por_i && (r.werr || r.state != FSQ_ST_IDLE);
    end
  end

  // Register the state
  always_ff @(posedge clk_i) begin
    r <= n;
  end

  // Outputs straight from flip-flops
  assign rdata_o = r.rdata;
  assign cpu_stall_o = r.stall;
  assign flash_addr_o = r.faddr;
  assign flash_wdata_o = r.fwdata;
  assign flash_prog_o = r.fprog;
  assign flash_erase_o = r.ferase;
  assign flash_rd_o = r.frd;

endmodule

`default_nettype wire

/* testbench/flash_self_program_sequencer_tb_top.sv */
// Bench: register port driver, read checker, flash model.
// Assumes a short long write and the checker bound to the design.
`default_nettype none
module flash_self_program_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LC = 80; // Short long write keeps the run brief
  logic clk_i = 1'b0, reset_i = 1'b1, por_i = 1'b1;
  logic we_i = 1'b0, re_i = 1'b0, re_d = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h0, rdata_o, fl_rd, fl_wd;
  logic [21:0] fl_a, b;
  logic stall, f_prog, f_er, f_rd;
  logic [31:0] rng = 32'h4f9d1d5e;
  logic [7:0] img [0:63]; // Expected block contents
  logic [7:0] q [$]; // Expected read data, oldest first
  int n_fail = 0, n_compared = 0;
  always #50 clk_i = ~clk_i;
  fsq_sequencer #(.LONG_CYC(LC)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .por_i(por_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .cpu_stall_o(stall),
    .flash_addr_o(fl_a), .flash_wdata_o(fl_wd), .flash_prog_o(f_prog),
    .flash_erase_o(f_er), .flash_rd_o(f_rd), .flash_rdata_i(fl_rd));
  fsq_flash_model flash_u (.clk_i(clk_i), .addr_i(fl_a), .wdata_i(fl_wd),
    .prog_i(f_prog), .erase_i(f_er), .rd_i(f_rd), .rdata_o(fl_rd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR rdata_o expected %h seen %h", exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One bus cycle; every bus task returns just after a rising edge
  task automatic op(input logic w, input logic r, input logic [2:0] a,
                    input logic [7:0] d);
    we_i <= w;
    re_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    q.push_back(e);
    op(1'b0, 1'b1, a, 8'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 3'h0, 8'h0);
  endtask
  task automatic ptr(input logic [21:0] p);
    op(1'b1, 1'b0, 3'h2, p[7:0]);
    op(1'b1, 1'b0, 3'h3, p[15:8]);
    op(1'b1, 1'b0, 3'h4, {2'h0, p[21:16]});
  endtask
  task automatic go(input logic [7:0] c);
    op(1'b1, 1'b0, 3'h1, 8'h55);
    op(1'b1, 1'b0, 3'h1, 8'haa);
    op(1'b1, 1'b0, 3'h0, c);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    idle(1);
    while (stall !== 1'b0 && k < 300) begin
      idle(1);
      k++;
    end
    if (k == 300) begin
      n_fail++;
      finish_test();
    end
  endtask
  // Single holding byte, then program; other bytes must stay erased
  task automatic put(input logic [21:0] a, input logic [7:0] v);
    ptr(a);
    op(1'b1, 1'b0, 3'h5, v);
    op(1'b1, 1'b0, 3'h6, 8'h00);
    go(8'h86);
    wait_done();
  endtask
  // Table reads with post-increment over one block
  task automatic verify(input logic [21:0] a);
    ptr(a);
    for (int i = 0; i < 64; i++) begin
      op(1'b1, 1'b0, 3'h6, 8'h05);
      idle(2);
      rd(3'h5, img[i]);
    end
  endtask
  // Read results stand one cycle after the strobe
  always @(posedge clk_i) re_d <= re_i;
  always @(negedge clk_i) begin
    if (re_d) begin
      if (q.size() == 0) n_fail++;
      else check(rdata_o, q.pop_front());
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
    rd(3'h0, 8'h00);
    rd(3'h7, 8'h00);
    op(1'b1, 1'b0, 3'h0, 8'h86);
    rd(3'h0, 8'h8c);
    op(1'b1, 1'b0, 3'h0, 8'h84);
    go(8'hc6);
    rd(3'h0, 8'hcc);
    op(1'b1, 1'b0, 3'h0, 8'h84);
    rng = xs(rng);
    b = {10'h0, rng[11:7], 1'b1, 6'h0};
    ptr(b - 22'h1);
    for (int i = 0; i < 64; i++) begin
      rng = xs(rng);
      img[i] = (i % 5 == 0) ? 8'hff : rng[7:0];
      op(1'b1, 1'b0, 3'h5, img[i]);
      op(1'b1, 1'b0, 3'h6, 8'h03);
    end
    go(8'h86);
    rd(3'h0, 8'h86);
    op(1'b1, 1'b0, 3'h5, 8'h12);
    wait_done();
    rd(3'h0, 8'h84);
    rd(3'h5, img[63]);
    verify(b);
    foreach (img[i]) img[i] = 8'hff;
    b = b ^ 22'h40;
    rng = xs(rng);
    img[5] = rng[7:0] | 8'h01;
    put(b + 22'h5, img[5]);
    verify(b);
    put(b + 22'h5, 8'hf0);
    img[5] = img[5] & 8'hf0;
    verify(b);
    ptr(b + 22'h21);
    go(8'h96);
    rd(3'h0, 8'h96);
    wait_done();
    foreach (img[i]) img[i] = 8'hff;
    verify(b);
    go(8'h86);
    idle(5);
    reset_i <= 1'b1;
    idle(1);
    reset_i <= 1'b0;
    rd(3'h0, 8'h08);
    por_i <= 1'b1;
    idle(1);
    por_i <= 1'b0;
    rd(3'h0, 8'h00);
    idle(3);
    finish_test();
  end
endmodule
`default_nettype wire

/* testbench/fsq_flash_model.sv */
// Flash array model: byte read, byte program, 64-byte erase.
// Assumes the sequencer's clock; only 4 KB mapped, upper bits alias.
`default_nettype none
module fsq_flash_model (
  input wire logic clk_i,
  input wire logic [21:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic prog_i,
  input wire logic erase_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:4095]; // Array image, erased at start
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    rdata_o = 8'h0;
  end
  // Answer a read next cycle; else scramble so stale data never passes
  always @(posedge clk_i) begin
    if (rd_i) rdata_o <= mem[addr_i[11:0]];
    else rdata_o <= ~rdata_o;
    if (prog_i) mem[addr_i[11:0]] <= mem[addr_i[11:0]] & wdata_i;
    if (erase_i) begin
      for (int i = 0; i < 64; i++) mem[{addr_i[11:6], i[5:0]}] <= 8'hff;
    end
  end
endmodule
`default_nettype wire

/* testbench/fsq_seq_monitor.sv */
// Checker for the flash sequencer ports.
// Assumes one clock; bound to each fsq_sequencer.
`default_nettype none
module fsq_seq_monitor #(
  parameter int LONG_CYC = 80
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [7:0] rdata_o,
  input wire logic cpu_stall_o,
  input wire logic [21:0] flash_addr_o,
  input wire logic [7:0] flash_wdata_o,
  input wire logic flash_prog_o,
  input wire logic flash_erase_o,
  input wire logic flash_rd_o,
  input wire logic [7:0] flash_rdata_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || por_i);
  logic [15:0] cnt_r; // Cycles seen with stall high
  // Either reset ends a stall, so the count restarts with it
  always_ff @(posedge clk_i)
    cnt_r <= (reset_i || por_i || !cpu_stall_o) ? 16'h0 : cnt_r + 16'h1;
  // Key pair then start, all while idle
  sequence unlock_s(bit e);
    we_i && addr_i == 3'h1 && wdata_i == 8'h55 && !cpu_stall_o ##1
    we_i && addr_i == 3'h1 && wdata_i == 8'haa ##1
    we_i && addr_i == 3'h0 && wdata_i[7:6] == 2'h2 && wdata_i[4] == e
    && wdata_i[2:1] == 2'h3 && !cpu_stall_o;
  endsequence
  AST_START_STALL: assert property (unlock_s(1'b0) or unlock_s(1'b1)
    |=> cpu_stall_o) else $error("no stall after unlock");
  AST_NO_KEY: assert property (we_i && addr_i == 3'h0 && wdata_i[1]
    && !cpu_stall_o && !$past(re_i) && !$past(we_i && addr_i == 3'h1
    && wdata_i == 8'haa) |=> !cpu_stall_o) else $error("start w/o key");
  AST_STALL_LEN: assert property ($fell(cpu_stall_o) && !$past(reset_i)
    && !$past(por_i) |-> cnt_r == 16'(LONG_CYC))
    else $error("stall length wrong");
  AST_TBL_SHORT: assert property (we_i && addr_i == 3'h6 && !wdata_i[2]
    && !cpu_stall_o |=> (!cpu_stall_o && !flash_prog_o)[*3])
    else $error("table write stalled or programmed");
  AST_IN_STALL: assert property (flash_prog_o || flash_erase_o
    |-> cpu_stall_o) else $error("array strobe outside stall");
  AST_ERASE_ALIGN: assert property (flash_erase_o
    |-> flash_addr_o[5:0] == 6'h0) else $error("erase not aligned");
  AST_SKIP_FF: assert property (flash_prog_o
    |-> flash_wdata_o != 8'hff) else $error("erased byte programmed");
  AST_ERASE_GO: assert property (unlock_s(1'b1)
    |-> ##2 flash_erase_o) else $error("erase not launched");
  AST_PROG_NO_ERASE: assert property (unlock_s(1'b0)
    |=> (!flash_erase_o)[*8]) else $error("erase during program");
  COV_PROG: cover property (unlock_s(1'b0));
  COV_ERASE: cover property (unlock_s(1'b1));
  COV_END: cover property ($fell(cpu_stall_o));
endmodule

bind fsq_sequencer fsq_seq_monitor #(.LONG_CYC(LONG_CYC)) mon_u (
  .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
  .cpu_stall_o(cpu_stall_o), .flash_addr_o(flash_addr_o),
  .flash_wdata_o(flash_wdata_o), .flash_prog_o(flash_prog_o),
  .flash_erase_o(flash_erase_o), .flash_rd_o(flash_rd_o),
  .flash_rdata_i(flash_rdata_i));
`default_nettype wire
